// ==== bench/dcd_ctl_model.sv ====
// Purpose: controller side of the serial command link
// Assumes: half bit period of five clk_sys cycles
// Notes: data line inverted when idle
`timescale 1ns/100ps
module dcd_ctl_model (
	input  wire logic clk_sys,
	output logic      cmd_clk,
	output logic      cmd_data,
	output logic      cmd_frame,
	input  wire logic resp_data,
	input  wire logic resp_valid
);
	initial begin
		cmd_clk = 1'b0;
		cmd_data = 1'b0;
		cmd_frame = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task automatic send(input logic [15:0] w, input logic bad, input int n,
		output logic [15:0] r, output logic got, output logic pok);
		logic [16:0] b;
		b = {w, ~^w ^ bad};
		cmd_frame <= 1'b1;
		for (int i = 16; i > 16 - n; i--) begin
			cmd_data <= b[i];
			tick(5);
			cmd_clk <= 1'b1;
			tick(5);
			cmd_clk <= 1'b0;
		end
		tick(10);
		got = resp_valid;
		for (int i = 16; i >= 0 && got; i--) begin
			b[i] = resp_data;
			cmd_clk <= 1'b1;
			tick(5);
			cmd_clk <= 1'b0;
			tick(5);
		end
		r = b[16:1];
		pok = ^b;
		cmd_frame <= 1'b0;
		cmd_data <= ~cmd_data;
		tick(10);
	endtask : send
endmodule : dcd_ctl_model

// ==== bench/dcd_top_sva.sv ====
// Purpose: port checks for dcd_top
// Assumes: zero wait state apb slave
// Notes: bound from the bench top
`timescale 1ns/100ps
module dcd_top_sva #(
	parameter int BANDS = 128
) (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        cmd_clk,
	input wire logic        cmd_data,
	input wire logic        cmd_frame,
	input wire logic        resp_data,
	input wire logic        resp_valid,
	input wire logic        attention,
	input wire logic        invalid_cmd,
	input wire logic        parity_err,
	input wire logic        seek_go,
	input wire logic [15:0] seek_target,
	input wire logic        seek_reverse,
	input wire logic        seek_relative
);
	logic [2:0] wr_reg;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	always_ff @(posedge clk_sys) begin
		wr_reg <= rst ? 3'h0 : {wr_reg[1:0], psel & penable & pwrite};
	end
	chk_ready_access: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
		else $error("pready outside access phase");
	chk_no_slverr: assert property (!pslverr) else $error("pslverr raised");
	chk_prdata_hold: assert property ($changed(prdata) |-> $past(psel && !pwrite))
		else $error("prdata moved without a read");
	chk_seek_pulse: assert property (seek_go |=> !seek_go) else $error("seek_go too long");
	chk_seek_clean: assert property (seek_go |-> !parity_err && !invalid_cmd)
		else $error("seek on refused command");
	chk_resp_clean: assert property (resp_valid |-> !parity_err && !invalid_cmd)
		else $error("response on refused command");
	chk_fwd_dir: assert property (seek_go && !seek_relative |-> !seek_reverse)
		else $error("direction on absolute seek");
	chk_target_hold: assert property (seek_go |=> $stable(seek_target) [*8])
		else $error("seek target moved");
	chk_attn_cause: assert property ($rose(attention) |-> |wr_reg)
		else $error("attention without status write");
endmodule : dcd_top_sva

// ==== bench/tb_disk_command_decoder.sv ====
// Purpose: self-checking bench for dcd_top
// Assumes: zero wait state apb, controller model on the link
// Notes: none
`timescale 1ns/100ps
module tb_disk_command_decoder;
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [15:0] w;
		logic [15:0] r;
		logic        inv;
	} dcd_row_s;
	logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pslverr, pready;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic cmd_clk, cmd_data, cmd_frame, resp_data, resp_valid, attention;
	logic invalid_cmd, parity_err, seek_go, seek_reverse, seek_relative, rg, rp;
	logic [15:0] seek_target, rw;
	int mismatches = 0, total_checks = 0, gos = 0, g0;
	dcd_row_s rows [19] = '{'{8'h10, 16'h2000, 16'h1234, 0}, '{8'h10, 16'h2001, 16'h00AB, 0},
		'{8'h10, 16'h2100, 16'h5A5A, 0}, '{8'h10, 16'h2800, 0, 1}, '{8'h10, 16'h2F00, 0, 1},
		'{8'h11, 16'h2800, 0, 1}, '{8'h11, 16'h2900, 16'h8000, 0}, '{8'h11, 16'h2E00, 0, 1},
		'{8'h11, 16'h2F00, 0, 1}, '{8'h11, 16'h2B00, 16'h0100, 0}, '{8'h11, 16'h2B01, 16'h01FF, 0},
		'{8'h11, 16'h2C03, 16'h0300, 0}, '{8'h11, 16'h2D00, 16'h0100, 0}, '{8'h11, 16'h2B04, 0, 1},
		'{8'h11, 16'h4000, 0, 1}, '{8'h11, 16'h9000, 0, 1}, '{8'h11, 16'hC000, 0, 1},
		'{8'h11, 16'hD000, 0, 1}, '{8'h11, 16'h3000, 16'h1234, 0}};
	dcd_top i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmd_clk(cmd_clk), .cmd_data(cmd_data), .cmd_frame(cmd_frame), .resp_data(resp_data),
		.resp_valid(resp_valid), .attention(attention), .invalid_cmd(invalid_cmd),
		.parity_err(parity_err), .seek_go(seek_go), .seek_target(seek_target),
		.seek_reverse(seek_reverse), .seek_relative(seek_relative));
	dcd_ctl_model i_ctl (.clk_sys(clk_sys), .cmd_clk(cmd_clk), .cmd_data(cmd_data),
		.cmd_frame(cmd_frame), .resp_data(resp_data), .resp_valid(resp_valid));
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (seek_go === 1'b1) gos++;
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
		q = prdata;
		chk("pready", pready, 1);
		chk("pslverr", pslverr, 0);
		psel <= 0;
		penable <= 0;
		@(posedge clk_sys);
	endtask : apb
	task automatic cmd(input logic [15:0] w, input logic bad = 0);
		i_ctl.send(w, bad, 17, rw, rg, rp);
	endtask : cmd
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	initial begin
		#250000;
		mismatches++;
		results();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 0;
		repeat (2) @(posedge clk_sys);
		chk("reset", {resp_valid, attention, invalid_cmd, parity_err, seek_go, seek_target}, 0);
		apb(1, 12'h004, 32'h1234);
		apb(1, 12'h008, 32'h00AB);
		apb(1, 12'h00C, 32'h8001);
		apb(1, 12'h010, 32'h5A5A);
		apb(1, 12'h014, 32'h0002);
		apb(1, 12'h118, 32'h0000_0100);
		apb(1, 12'h118, 32'h0001_01FF);
		apb(1, 12'h118, 32'h0003_0300);
		$display("preload done");
		foreach (rows[i]) begin
			apb(1, 12'h000, rows[i].ctrl);
			cmd(rows[i].w);
			chk("invalid", invalid_cmd, rows[i].inv);
			chk("got", rg, !rows[i].inv);
			// bands polled from band 0 up to the absent one
			if (!rows[i].inv) chk("resp", {rp, rw}, {1'b1, rows[i].r});
		end
		$display("table done");
		apb(1, 12'h000, 0);
		cmd(16'h7005);
		cmd(16'h6003);
		g0 = gos;
		cmd(16'h0ABC);
		chk("mag seek", {gos - g0, seek_relative, seek_target}, {32'h1, 1'b0, 16'h0ABC});
		apb(0, 12'h028, 0);
		chk("toff", q, 0);
		apb(0, 12'h024, 0);
		chk("droff", q, 0);
		cmd(16'h7005);
		cmd(16'h1000);
		apb(0, 12'h028, 0);
		chk("mag recal", {q[15:0], seek_target}, 0);
		$display("magnetic done");
		apb(1, 12'h000, 1);
		cmd(16'hA003);
		cmd(16'h0123);
		chk("abs seek", seek_target, 16'h3123);
		cmd(16'h0001);
		chk("held high", seek_target, 16'h3001);
		cmd(16'h6003);
		g0 = gos;
		cmd(16'h1000);
		apb(0, 12'h024, 0);
		chk("abs recal", {gos - g0, q[15:0], seek_target}, {32'h1, 32'h0});
		apb(1, 12'h000, 3);
		cmd(16'hA105);
		cmd(16'h0010);
		chk("rel seek", {seek_reverse, seek_relative, seek_target}, {2'b11, 16'h5010});
		cmd(16'h6003);
		g0 = gos;
		cmd(16'h1000);
		apb(0, 12'h024, 0);
		chk("rel recal", {gos - g0, q}, 0);
		cmd(16'h0111, 1);
		chk("bad parity", {parity_err, rg, gos - g0, seek_target}, {2'b10, 32'h0, 16'h5010});
		$display("optical done");
		apb(1, 12'h000, 8'h11);
		apb(1, 12'h014, 32'h0080);
		apb(1, 12'h118, 32'h00FF_7FFF);
		cmd(16'h2BFF);
		chk("band 128", rw, 16'h7FFF);
		apb(1, 12'h004, 32'hF000);
		@(posedge clk_sys);
		chk("attn high bits", attention, 0);
		apb(1, 12'h004, 32'hF001);
		@(posedge clk_sys);
		chk("attn low bits", attention, 1);
		i_ctl.send(16'h2000, 0, 8, rw, rg, rp);
		cmd(16'h2000);
		chk("status after cut", {attention, rw}, 17'h0F001);
		apb(0, 12'h0FC, 0);
		chk("unmapped", q, 0);
		rst <= 1;
		repeat (3) @(posedge clk_sys);
		rst <= 0;
		repeat (2) @(posedge clk_sys);
		chk("mid reset", {attention, seek_relative, seek_reverse, seek_target}, 0);
		apb(0, 12'h000, 0);
		chk("ctrl after reset", q, 0);
		$display("awkward cases done");
		results();
	end
endmodule : tb_disk_command_decoder
bind dcd_top dcd_top_sva #(.BANDS(BANDS)) i_sva (.clk_sys(clk_sys), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .cmd_clk(cmd_clk), .cmd_data(cmd_data),
	.cmd_frame(cmd_frame), .resp_data(resp_data), .resp_valid(resp_valid),
	.attention(attention), .invalid_cmd(invalid_cmd), .parity_err(parity_err),
	.seek_go(seek_go), .seek_target(seek_target), .seek_reverse(seek_reverse),
	.seek_relative(seek_relative));

// ==== shared/dcd_map.svh ====
// Purpose: constants for the disk command decoder
// Assumes: 17-bit serial words, 16 data bits then odd parity
// Notes:   register offsets are byte addresses on the apb bus
`ifndef DCD_MAP_SVH
`define DCD_MAP_SVH
`define DCD_WORD_BITS      5'h11
`define DCD_DATA_BITS      5'h10
`define DCD_FUNC_HI        15
`define DCD_FUNC_LO        12
`define DCD_MOD_HI         11
`define DCD_MOD_LO         8
`define DCD_PARAM_HI       11
`define DCD_SUB_HI         7
`define DCD_ATT_HI         11
`define DCD_BAND_MAX       8'h80
`define DCD_ADDR_CTRL      12'h000
`define DCD_ADDR_STD       12'h004
`define DCD_ADDR_EXT       12'h008
`define DCD_ADDR_DEV       12'h00C
`define DCD_ADDR_VU        12'h010
`define DCD_ADDR_BANDS     12'h014
`define DCD_ADDR_POS       12'h018
`define DCD_ADDR_STAT      12'h01C
`define DCD_ADDR_LAST      12'h020
`define DCD_ADDR_DROFF     12'h024
`define DCD_ADDR_TOFF      12'h028
`define DCD_ADDR_BAND_WR   12'h118
`define DCD_CTRL_OPTICAL   0
`define DCD_CTRL_RELATIVE  1
`define DCD_CTRL_VU_CNT_LO 4
`define DCD_CTRL_VU_CNT_HI 7
`define DCD_CTRL_RESET     32'h0000_0000
`endif

// ==== shared/dcd_pkg.sv ====
// Purpose: types for the disk command decoder
// Assumes: function codes are the four high bits of a command word
// Notes:   none
package dcd_pkg;
	typedef enum logic [3:0] {
		DCD_F_SEEK    = 4'h0,
		DCD_F_RECAL   = 4'h1,
		DCD_F_STATUS  = 4'h2,
		DCD_F_CONFIG  = 4'h3,
		DCD_F_HEAD    = 4'h4,
		DCD_F_CONTROL = 4'h5,
		DCD_F_DROFF   = 4'h6,
		DCD_F_TOFF    = 4'h7,
		DCD_F_DIAG    = 4'h8,
		DCD_F_BPS     = 4'h9,
		DCD_F_HIGH    = 4'hA,
		DCD_F_FORMAT  = 4'hB,
		DCD_F_RSV_C   = 4'hC,
		DCD_F_RSV_D   = 4'hD,
		DCD_F_SETCFG  = 4'hE,
		DCD_F_LINK    = 4'hF
	} dcd_func_e;
	typedef enum logic [1:0] {
		DCD_S_IDLE = 2'b00,
		DCD_S_RX   = 2'b01,
		DCD_S_EXEC = 2'b11,
		DCD_S_TX   = 2'b10
	} dcd_state_e;
endpackage : dcd_pkg

// ==== src/dcd_top.sv ====
// Purpose: drive-side interpreter of serial disk command words
// Assumes: command and response bits are sampled from pins, msb first,
//          one bit per cmd_clk rising edge; parity bit follows bit 0
// Notes:   apb slave holds mode, status sources and the band table
`timescale 1ns/100ps
`include "dcd_map.svh"
module dcd_top #(
	parameter int BANDS = 128
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cmd_clk,
	input  wire logic        cmd_data,
	input  wire logic        cmd_frame,
	output logic             resp_data,
	output logic             resp_valid,
	output logic             attention,
	output logic             invalid_cmd,
	output logic             parity_err,
	output logic             seek_go,
	output logic [15:0]      seek_target,
	output logic             seek_reverse,
	output logic             seek_relative
);
	// pin synchronisers, three stages each
	logic [2:0] clk_sync_reg;
	logic [2:0] dat_sync_reg;
	logic [2:0] frm_sync_reg;
	logic       clk_lvl_reg;
	logic       frm_lvl_reg;
	logic       dat_lvl_reg;

	dcd_pkg::dcd_state_e state_reg;
	logic [16:0] shift_reg;
	logic [4:0]  bit_cnt_reg;
	logic [16:0] tx_reg;
	logic [4:0]  tx_cnt_reg;
	logic        optical_reg;
	logic        relative_reg;
	logic [3:0]  vu_count_reg;
	logic [15:0] std_stat_reg;
	logic [15:0] ext_stat_reg;
	logic [15:0] dev_stat_reg;
	logic [15:0] vu_stat_reg;
	logic [15:0] band_cnt_reg;
	logic [15:0] track_reg;
	logic [3:0]  high_bits_reg;
	logic [1:0]  dir_bits_reg;
	logic [15:0] last_cmd_reg;
	logic [7:0]  drec_off_reg;
	logic [7:0]  trk_off_reg;
	logic [15:0] band_mem [0:2*BANDS-1];
	logic [15:0] old_att_reg;
	logic        clk_rise;
	logic        frm_now;
	logic        apb_wr;
	logic        apb_rd;
	logic [15:0] word;
	logic [3:0]  func;
	logic [3:0]  modf;
	logic [7:0]  sub;
	logic        resp_bad;
	logic [15:0] resp_word;
	logic        is_resp;
	logic        func_bad;
	logic        par_ok;
	function automatic logic odd_par(input logic [15:0] d);
		odd_par = ~(^d);
	endfunction : odd_par
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clk_sync_reg <= 3'h0;
			dat_sync_reg <= 3'h0;
			frm_sync_reg <= 3'h0;
		end else begin
			clk_sync_reg <= {clk_sync_reg[1:0], cmd_clk};
			dat_sync_reg <= {dat_sync_reg[1:0], cmd_data};
			frm_sync_reg <= {frm_sync_reg[1:0], cmd_frame};
		end
	end
	// a change counts once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clk_lvl_reg <= 1'b0;
			frm_lvl_reg <= 1'b0;
			dat_lvl_reg <= 1'b0;
		end else begin
			if (clk_sync_reg[1] == clk_sync_reg[2])
				clk_lvl_reg <= clk_sync_reg[2];
			if (frm_sync_reg[1] == frm_sync_reg[2])
				frm_lvl_reg <= frm_sync_reg[2];
			if (dat_sync_reg[1] == dat_sync_reg[2])
				dat_lvl_reg <= dat_sync_reg[2];
		end
	end
	assign clk_rise = (clk_sync_reg[1] == clk_sync_reg[2]) && clk_sync_reg[2] && !clk_lvl_reg;
	assign frm_now  = frm_lvl_reg;
	assign word = shift_reg[16:1];
	assign func = word[`DCD_FUNC_HI:`DCD_FUNC_LO];
	assign modf = word[`DCD_MOD_HI:`DCD_MOD_LO];
	assign sub  = word[`DCD_SUB_HI:0];

	always_comb begin
		case (dcd_pkg::dcd_func_e'(func))
			dcd_pkg::DCD_F_HEAD,
			dcd_pkg::DCD_F_BPS:    func_bad = optical_reg;
			dcd_pkg::DCD_F_FORMAT: func_bad = !optical_reg;
			dcd_pkg::DCD_F_RSV_C,
			dcd_pkg::DCD_F_RSV_D,
			dcd_pkg::DCD_F_LINK:   func_bad = 1'b1;
			default:               func_bad = 1'b0;
		endcase
	end

	always_comb begin
		resp_word = 16'h0000;
		resp_bad  = 1'b0;
		if (modf == 4'h0) begin
			if (sub == 8'h00)
				resp_word = std_stat_reg;
			else if (sub == 8'h01)
				resp_word = ext_stat_reg;
			else
				resp_bad = 1'b1;
		end else if (!modf[3]) begin
			// vendor words up to configured count
			resp_word = vu_stat_reg;
			resp_bad  = ({1'b0, modf[2:0]} > vu_count_reg);
		end else if (!optical_reg) begin
			resp_bad = 1'b1;
		end else begin
			case (modf)
				4'h9: resp_word = dev_stat_reg;
				4'hA: begin
					resp_word = track_reg;
					resp_bad  = relative_reg;
				end
				4'hB, 4'hC, 4'hD: begin
					resp_word = band_mem[sub];
					resp_bad  = ({9'h000, sub[7:1]} >= band_cnt_reg);
				end
				default: resp_bad = 1'b1;
			endcase
		end
	end

	assign is_resp = (func == dcd_pkg::DCD_F_STATUS) || (func == dcd_pkg::DCD_F_CONFIG);
	assign par_ok  = (shift_reg[0] == odd_par(word));
	assign apb_wr  = psel && penable && pwrite && pready;
	assign apb_rd  = psel && !penable && !pwrite;

	// receive, execute, transmit sequence
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg   <= dcd_pkg::DCD_S_IDLE;
			shift_reg   <= 17'h0;
			bit_cnt_reg <= 5'h0;
			tx_reg      <= 17'h0;
			tx_cnt_reg  <= 5'h0;
			resp_data   <= 1'b0;
			resp_valid  <= 1'b0;
			invalid_cmd <= 1'b0;
			parity_err  <= 1'b0;
			seek_go     <= 1'b0;
			last_cmd_reg <= 16'h0;
		end else begin
			seek_go <= 1'b0;
			case (state_reg)
				dcd_pkg::DCD_S_IDLE: begin
					resp_valid  <= 1'b0;
					bit_cnt_reg <= 5'h0;
					if (frm_now)
						state_reg <= dcd_pkg::DCD_S_RX;
				end
				dcd_pkg::DCD_S_RX: begin
					if (clk_rise) begin
						shift_reg   <= {shift_reg[15:0], dat_lvl_reg};
						bit_cnt_reg <= bit_cnt_reg + 5'h1;
						if (bit_cnt_reg == `DCD_WORD_BITS - 5'h1)
							state_reg <= dcd_pkg::DCD_S_EXEC;
					end else if (!frm_now) begin
						state_reg <= dcd_pkg::DCD_S_IDLE;
					end
				end
				dcd_pkg::DCD_S_EXEC: begin
					last_cmd_reg <= word;
					if (!par_ok) begin
						parity_err <= 1'b1;
						state_reg  <= dcd_pkg::DCD_S_IDLE;
					end else begin
						parity_err  <= 1'b0;
						invalid_cmd <= func_bad || (func == 4'h2 && resp_bad);
						seek_go     <= !func_bad && (func == dcd_pkg::DCD_F_SEEK
							|| (func == dcd_pkg::DCD_F_RECAL && !optical_reg)
							|| (func == dcd_pkg::DCD_F_RECAL && !relative_reg));
						if (is_resp && !(func == 4'h2 && resp_bad)) begin
							tx_reg     <= {resp_word, odd_par(resp_word)};
							tx_cnt_reg <= `DCD_WORD_BITS;
							state_reg  <= dcd_pkg::DCD_S_TX;
						end else begin
							state_reg <= dcd_pkg::DCD_S_IDLE;
						end
					end
				end
				dcd_pkg::DCD_S_TX: begin
					resp_valid <= 1'b1;
					resp_data  <= tx_reg[16];
					if (clk_rise) begin
						tx_reg     <= {tx_reg[15:0], 1'b0};
						tx_cnt_reg <= tx_cnt_reg - 5'h1;
						if (tx_cnt_reg == 5'h1)
							state_reg <= dcd_pkg::DCD_S_IDLE;
					end
				end
				default: state_reg <= dcd_pkg::DCD_S_IDLE;
			endcase
		end
	end

	// seek, recalibrate and offset effects
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			seek_target   <= 16'h0;
			seek_reverse  <= 1'b0;
			seek_relative <= 1'b0;
			track_reg     <= 16'h0;
			high_bits_reg <= 4'h0;
			dir_bits_reg  <= 2'h0;
			drec_off_reg  <= 8'h00;
			trk_off_reg   <= 8'h00;
		end else if (state_reg == dcd_pkg::DCD_S_EXEC && par_ok && !func_bad) begin
			case (dcd_pkg::dcd_func_e'(func))
				dcd_pkg::DCD_F_SEEK: begin
					seek_relative <= optical_reg && relative_reg;
					if (!optical_reg) begin
						seek_target  <= {4'h0, word[`DCD_PARAM_HI:0]};
						track_reg    <= {4'h0, word[`DCD_PARAM_HI:0]};
						seek_reverse <= 1'b0;
						drec_off_reg <= 8'h00;
						trk_off_reg  <= 8'h00;
					end else if (!relative_reg) begin
						seek_target  <= {high_bits_reg, word[`DCD_PARAM_HI:0]};
						track_reg    <= {high_bits_reg, word[`DCD_PARAM_HI:0]};
						seek_reverse <= 1'b0;
					end else begin
						seek_target  <= {high_bits_reg, word[`DCD_PARAM_HI:0]};
						seek_reverse <= dir_bits_reg[0];
					end
				end
				dcd_pkg::DCD_F_RECAL: begin
					drec_off_reg <= 8'h00;
					if (!optical_reg || !relative_reg) begin
						seek_target   <= 16'h0;
						track_reg     <= 16'h0;
						seek_reverse  <= 1'b0;
						seek_relative <= 1'b0;
					end
					if (!optical_reg)
						trk_off_reg <= 8'h00;
				end
				dcd_pkg::DCD_F_HIGH: begin
					high_bits_reg <= word[3:0];
					dir_bits_reg  <= word[9:8];
				end
				dcd_pkg::DCD_F_DROFF: drec_off_reg <= sub;
				dcd_pkg::DCD_F_TOFF:  trk_off_reg  <= sub;
				default: ;
			endcase
		end
	end

	// attention from rising bits 11-0 only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			attention   <= 1'b0;
			old_att_reg <= 16'h0;
		end else begin
			old_att_reg <= std_stat_reg;
			if (|(std_stat_reg[`DCD_ATT_HI:0] & ~old_att_reg[`DCD_ATT_HI:0]))
				attention <= 1'b1;
			else if (state_reg == dcd_pkg::DCD_S_EXEC && par_ok && func == dcd_pkg::DCD_F_STATUS)
				attention <= 1'b0;
		end
	end

	// apb register writes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			optical_reg  <= 1'b0;
			relative_reg <= 1'b0;
			vu_count_reg <= 4'h0;
			std_stat_reg <= 16'h0;
			ext_stat_reg <= 16'h0;
			dev_stat_reg <= 16'h0;
			vu_stat_reg  <= 16'h0;
			band_cnt_reg <= 16'h0;
		end else if (apb_wr) begin
			case (paddr)
				`DCD_ADDR_CTRL: begin
					optical_reg  <= pwdata[`DCD_CTRL_OPTICAL];
					relative_reg <= pwdata[`DCD_CTRL_RELATIVE];
					vu_count_reg <= pwdata[`DCD_CTRL_VU_CNT_HI:`DCD_CTRL_VU_CNT_LO];
				end
				`DCD_ADDR_STD:   std_stat_reg <= pwdata[15:0];
				`DCD_ADDR_EXT:   ext_stat_reg <= pwdata[15:0];
				`DCD_ADDR_DEV:   dev_stat_reg <= {pwdata[15:1], 1'b0};
				`DCD_ADDR_VU:    vu_stat_reg  <= pwdata[15:0];
				`DCD_ADDR_BANDS: band_cnt_reg <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// band table: word index in bits 23:16, track in 15:0
	always_ff @(posedge clk_sys) begin
		if (apb_wr && paddr == `DCD_ADDR_BAND_WR)
			band_mem[pwdata[23:16]] <= pwdata[15:0];
	end

	// apb read data and answer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (apb_rd) begin
				case (paddr)
					`DCD_ADDR_CTRL:  prdata <= {24'h0, vu_count_reg, 2'h0, relative_reg,
								optical_reg};
					`DCD_ADDR_STD:   prdata <= {16'h0, std_stat_reg};
					`DCD_ADDR_EXT:   prdata <= {16'h0, ext_stat_reg};
					`DCD_ADDR_DEV:   prdata <= {16'h0, dev_stat_reg};
					`DCD_ADDR_VU:    prdata <= {16'h0, vu_stat_reg};
					`DCD_ADDR_BANDS: prdata <= {16'h0, band_cnt_reg};
					`DCD_ADDR_POS:   prdata <= {16'h0, track_reg};
					`DCD_ADDR_STAT:  prdata <= {26'h0, dir_bits_reg, high_bits_reg};
					`DCD_ADDR_LAST:  prdata <= {16'h0, last_cmd_reg};
					`DCD_ADDR_DROFF: prdata <= {24'h0, drec_off_reg};
					`DCD_ADDR_TOFF:  prdata <= {24'h0, trk_off_reg};
					default:         prdata <= 32'h0;
				endcase
			end
		end
	end
endmodule : dcd_top
